// ==== rtl/cfg_pkg.sv ====
// constants shared by both ends of the clock driver configuration port
// Functional notes
// - write starts with address d2, device acknowledges
// - host sends command then count before data
// - dummy command and count acknowledged, then discarded
// - data bytes fill latch 0 to 5, each acknowledged
// - ascending order, early end keeps received bytes
// - loading continues until stop condition
// - host ends every write with stop
// - only block writes supported
// - read starts with address d3, device acknowledges
// - device sends byte count first, host acknowledges
// - latches 0 to 5 follow, host acks, stops
// - read-back shows current latch values
// - slave only, up to 100 kbit/s
// - eight-bit bytes each followed by acknowledge
// - latches take defaults at reset
// - latch 0 bits enable pairs 0-7
// - latch 1: pairs 8-9, tri-state, bypass
// - host never writes latch 5
package cfg_pkg;
  localparam logic [7:0] WR_ADDR = 8'hd2;
  localparam logic [7:0] RD_ADDR = 8'hd3;
  localparam int NUM_LATCH = 6;
  localparam int DUMMY_BYTES = 2;
  localparam logic [7:0] LATCH0_DEF = 8'hff;
  localparam logic [7:0] LATCH1_DEF = 8'hc0;
  localparam logic [7:0] LATCH2_DEF = 8'hff;
  localparam logic [7:0] LATCH3_DEF = 8'hff;
  localparam logic [7:0] LATCH4_DEF = 8'hff;
  localparam logic [7:0] LATCH5_DEF = 8'h06;
  localparam int PAIR8_BIT = 7;
  localparam int PAIR9_BIT = 6;
  localparam int TRI_BIT = 4;
  localparam int BYP_BIT = 3;
  // bus timing
  localparam int CLK_NS = 8;
  localparam int BIT_NS = 10000;
  localparam int QTR_CYC = (BIT_NS / 4 + CLK_NS - 1) / CLK_NS;
  // host register map
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STAT_OFF = 8'h04;
  localparam logic [7:0] WLO_OFF = 8'h08;
  localparam logic [7:0] WHI_OFF = 8'h0c;
  localparam logic [7:0] RLO_OFF = 8'h10;
  localparam logic [7:0] RHI_OFF = 8'h14;
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_RD_BIT = 1;
  localparam int CTRL_N_LSB = 2;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_NACK_BIT = 1;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ==== rtl/cfg_bus_if.sv ====
// two-wire bus between host and clock driver, resolves open-drain lines
interface cfg_bus_if;
  logic scl_out;
  logic scl_oe;
  logic host_sda_out;
  logic host_sda_oe;
  logic dev_sda_out;
  logic dev_sda_oe;
  logic scl_line;
  logic sda_line;
  // pulled high unless an enabled driver pulls low
  assign scl_line = scl_oe ? scl_out : 1'b1;
  assign sda_line = ~((host_sda_oe & ~host_sda_out) | (dev_sda_oe & ~dev_sda_out));
  modport host(output scl_out, output scl_oe, output host_sda_out, output host_sda_oe, input sda_line);
  modport device(input scl_line, input sda_line, output dev_sda_out, output dev_sda_oe);
endinterface

// ==== rtl/pin_sync.sv ====
// two-flop synchroniser for pin inputs
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] sync
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;
  // one pair of flops per bit, idle level high
  for (genvar i = 0; i < WIDTH; i++)
  begin : g_bit
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        meta_reg[i] <= 1'b1;
        sync_reg[i] <= 1'b1;
      end
      else
      begin
        meta_reg[i] <= pin[i];
        sync_reg[i] <= meta_reg[i];
      end
    end
  end
  assign sync = sync_reg;
endmodule // pin_sync

// ==== rtl/cfg_device.sv ====
// clock driver configuration slave with its six latches
module cfg_device (
  input wire logic aclk,
  input wire logic aresetn,
  cfg_bus_if.device bus,
  output logic [9:0] pair_enable,
  output logic tristate_mode,
  output logic bypass_mode
);
  import cfg_pkg::*;

  typedef enum logic [2:0] {D_IDLE, D_ADDR, D_ACK, D_WDATA, D_TX, D_HACK} dstate_t;

  dstate_t state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] sh_reg, sh_next;
  logic [3:0] idx_reg, idx_next;
  logic rd_reg, rd_next;
  logic oe_reg, oe_next;
  logic [7:0] latch_reg [NUM_LATCH];
  logic [7:0] latch_next [NUM_LATCH];
  logic [1:0] lines;
  logic scl_s, sda_s, scl_d, sda_d;
  logic scl_rise, scl_fall, start_c, stop_c;
  logic [7:0] tx_byte;
  logic [2:0] wsel;
  logic [2:0] rsel;

  // pins pass two flops before use
  pin_sync #(.WIDTH(2)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin({bus.scl_line, bus.sda_line}),
    .sync(lines)
  );
  assign scl_s = lines[1];
  assign sda_s = lines[0];

  // previous line levels for edge and condition detection
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // bus events
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_c = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_c = scl_s & scl_d & ~sda_d & sda_s;

  // byte offered on read: count first, then latches
  assign rsel = 3'(idx_reg - 4'd1);
  assign wsel = 3'(idx_reg - 4'(DUMMY_BYTES));
  assign tx_byte = (idx_reg == 4'd0) ? 8'(NUM_LATCH) : latch_reg[rsel];

  // next-state logic of the slave
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    idx_next = idx_reg;
    rd_next = rd_reg;
    oe_next = oe_reg;
    latch_next = latch_reg;
    if (stop_c)
    begin
      state_next = D_IDLE;
      oe_next = 1'b0;
    end
    else if (start_c)
    begin
      state_next = D_ADDR;
      cnt_next = 4'd0;
      oe_next = 1'b0;
    end
    else
    begin
      unique case (state_reg)
        D_IDLE:
        begin
          oe_next = 1'b0;
        end
        D_ADDR, D_WDATA:
        begin
          if (scl_rise)
          begin
            sh_next = {sh_reg[6:0], sda_s};
            cnt_next = cnt_reg + 4'd1;
          end
          else if (scl_fall && cnt_reg == 4'd8)
          begin
            cnt_next = 4'd0;
            state_next = D_ACK;
            oe_next = 1'b1;
            if (state_reg == D_ADDR)
            begin
              idx_next = 4'd0;
              if (sh_reg == WR_ADDR)
                rd_next = 1'b0;
              else if (sh_reg == RD_ADDR)
                rd_next = 1'b1;
              else
              begin
                state_next = D_IDLE;
                oe_next = 1'b0;
              end
            end
            else if (idx_reg == 4'(DUMMY_BYTES + NUM_LATCH))
            begin
              state_next = D_IDLE; // no seventh latch: not acknowledged
              oe_next = 1'b0;
            end
            else
            begin
              if (idx_reg >= 4'(DUMMY_BYTES))
                latch_next[wsel] = sh_reg;
              idx_next = idx_reg + 4'd1;
            end
          end
        end
        D_ACK:
        begin
          if (scl_fall)
          begin
            cnt_next = 4'd0;
            if (rd_reg)
            begin
              state_next = D_TX;
              sh_next = {tx_byte[6:0], 1'b0};
              oe_next = ~tx_byte[7];
            end
            else
            begin
              state_next = D_WDATA;
              oe_next = 1'b0;
            end
          end
        end
        D_TX:
        begin
          if (scl_rise)
            cnt_next = cnt_reg + 4'd1;
          else if (scl_fall)
          begin
            if (cnt_reg == 4'd8)
            begin
              oe_next = 1'b0;
              state_next = D_HACK;
            end
            else
            begin
              oe_next = ~sh_reg[7];
              sh_next = {sh_reg[6:0], 1'b0};
            end
          end
        end
        D_HACK:
        begin
          if (scl_rise)
          begin
            if (!sda_s && idx_reg < 4'(NUM_LATCH))
            begin
              idx_next = idx_reg + 4'd1;
              state_next = D_ACK;
            end
            else
              state_next = D_IDLE;
          end
        end
      endcase
    end
  end

  // slave registers, latches load defaults at reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= D_IDLE;
      cnt_reg <= 4'd0;
      sh_reg <= 8'h00;
      idx_reg <= 4'd0;
      rd_reg <= 1'b0;
      oe_reg <= 1'b0;
      latch_reg[0] <= LATCH0_DEF;
      latch_reg[1] <= LATCH1_DEF;
      latch_reg[2] <= LATCH2_DEF;
      latch_reg[3] <= LATCH3_DEF;
      latch_reg[4] <= LATCH4_DEF;
      latch_reg[5] <= LATCH5_DEF;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      idx_reg <= idx_next;
      rd_reg <= rd_next;
      oe_reg <= oe_next;
      latch_reg <= latch_next;
    end
  end

  // open-drain data line: only ever pulls low
  assign bus.dev_sda_out = 1'b0;
  assign bus.dev_sda_oe = oe_reg;

  // latch 0 msb enables pair 0
  for (genvar i = 0; i < 8; i++)
  begin : g_pair
    assign pair_enable[i] = latch_reg[0][7-i];
  end
  assign pair_enable[8] = latch_reg[1][PAIR8_BIT];
  assign pair_enable[9] = latch_reg[1][PAIR9_BIT];
  assign tristate_mode = latch_reg[1][TRI_BIT];
  assign bypass_mode = latch_reg[1][BYP_BIT];
endmodule // cfg_device

// ==== rtl/cfg_host.sv ====
// bus host: axi4-lite registers drive block writes and reads
//
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
module cfg_host #(
  parameter int QTR = cfg_pkg::QTR_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  cfg_bus_if.host bus
);
  import cfg_pkg::*;

  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} hstate_t;

  hstate_t st_reg, st_next;
  logic [15:0] q_reg, q_next;
  logic [1:0] ph_reg, ph_next;
  logic [3:0] bit_reg, bit_next;
  logic [3:0] bidx_reg, bidx_next;
  logic [7:0] sh_reg, sh_next;
  logic rd_reg, rd_next, oe_reg, oe_next, sclh_reg, sclh_next, nack_reg, nack_next;
  logic [2:0] n_reg, n_next;
  logic [47:0] wb_reg, wb_next;
  logic [55:0] rb_reg, rb_next;
  logic awh_reg, awh_next, wh_reg, wh_next, bv_reg, bv_next, rv_reg, rv_next;
  logic [7:0] aa_reg, aa_next;
  logic [31:0] wd_reg, wd_next, rd_data_reg, rd_data_next;
  logic [3:0] ws_reg, ws_next;
  logic [1:0] br_reg, br_next, rr_reg, rr_next;
  logic sda_s, tick, rx, do_wr;
  logic [3:0] last;
  logic [2:0] nreq;
  logic [7:0] first;

  pin_sync #(.WIDTH(1)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(bus.sda_line),
    .sync(sda_s)
  );

  // quarter-bit enable, bus bit rate 100 kbit/s
  assign tick = (q_reg == 16'(QTR - 1));
  assign rx = rd_reg && bidx_reg != 4'd0;
  assign last = rd_reg ? 4'(NUM_LATCH + 1) : 4'(DUMMY_BYTES) + {1'b0, n_reg};
  assign do_wr = awh_reg && wh_reg && !bv_reg;
  assign nreq = (wd_reg[CTRL_N_LSB+:3] > 3'(NUM_LATCH - 1)) ? 3'(NUM_LATCH - 1) : wd_reg[CTRL_N_LSB+:3];
  assign first = wd_reg[CTRL_RD_BIT] ? RD_ADDR : WR_ADDR;

  // byte sent at position k: address, dummy command, count, data
  function automatic logic [7:0] tx_byte(input logic [3:0] k, input logic rd, input logic [2:0] n,
                                          input logic [47:0] wb);
    logic [3:0] d;
    d = k - 4'd3;
    if (k == 4'd0)
      tx_byte = rd ? RD_ADDR : WR_ADDR;
    else if (k == 4'd1)
      tx_byte = 8'h00;
    else if (k == 4'd2)
      tx_byte = {5'd0, n};
    else
      tx_byte = wb[{d[2:0], 3'd0}+:8];
  endfunction

  // next values of bus engine and register slave
  always_comb
  begin
    st_next = st_reg;
    q_next = (st_reg == H_IDLE || tick) ? 16'd0 : q_reg + 16'd1;
    ph_next = ph_reg;
    bit_next = bit_reg;
    bidx_next = bidx_reg;
    sh_next = sh_reg;
    rd_next = rd_reg;
    oe_next = oe_reg;
    sclh_next = sclh_reg;
    nack_next = nack_reg;
    n_next = n_reg;
    wb_next = wb_reg;
    rb_next = rb_reg;
    awh_next = awh_reg | (awvalid & ~awh_reg);
    aa_next = (awvalid && !awh_reg) ? awaddr : aa_reg;
    wh_next = wh_reg | (wvalid & ~wh_reg);
    wd_next = (wvalid && !wh_reg) ? wdata : wd_reg;
    ws_next = (wvalid && !wh_reg) ? wstrb : ws_reg;
    bv_next = bv_reg & ~bready;
    br_next = br_reg;
    rv_next = rv_reg & ~rready;
    rr_next = rr_reg;
    rd_data_next = rd_data_reg;
    if (tick && st_reg != H_IDLE)
    begin
      ph_next = ph_reg + 2'd1;
      unique case (st_reg)
        H_START:
        begin
          if (ph_reg == 2'd0)
            oe_next = 1'b1;
          else if (ph_reg == 2'd1)
          begin
            sclh_next = 1'b0;
            st_next = H_BIT;
            ph_next = 2'd0;
          end
        end
        H_BIT:
        begin
          unique case (ph_reg)
            2'd0: oe_next = (bit_reg == 4'd8) ? rx : (!rx && !sh_reg[7]);
            2'd1: sclh_next = 1'b1;
            2'd2:
            begin
              if (bit_reg != 4'd8)
                sh_next = {sh_reg[6:0], sda_s};
              else if (!rx && sda_s)
                nack_next = 1'b1;
            end
            2'd3:
            begin
              sclh_next = 1'b0;
              bit_next = bit_reg + 4'd1;
              if (bit_reg == 4'd8)
              begin
                bit_next = 4'd0;
                if (rx)
                  rb_next[{bidx_reg[2:0] - 3'd1, 3'd0}+:8] = sh_reg;
                if (nack_reg || bidx_reg == last)
                  st_next = H_STOP;
                else
                begin
                  bidx_next = bidx_reg + 4'd1;
                  sh_next = tx_byte(bidx_reg + 4'd1, rd_reg, n_reg, wb_reg);
                end
              end
            end
          endcase
        end
        H_STOP:
        begin
          unique case (ph_reg)
            2'd0: oe_next = 1'b1;
            2'd1: sclh_next = 1'b1;
            2'd2: oe_next = 1'b0;
            2'd3: st_next = H_IDLE;
          endcase
        end
        default: st_next = H_IDLE;
      endcase
    end
    // register writes once address and data are both held
    if (do_wr)
    begin
      awh_next = 1'b0;
      wh_next = 1'b0;
      bv_next = 1'b1;
      br_next = RESP_OKAY;
      unique case (aa_reg)
        CTRL_OFF:
        begin
          if (ws_reg[0] && wd_reg[CTRL_GO_BIT] && st_reg == H_IDLE)
          begin
            st_next = H_START;
            ph_next = 2'd0;
            bit_next = 4'd0;
            bidx_next = 4'd0;
            nack_next = 1'b0;
            rd_next = wd_reg[CTRL_RD_BIT];
            n_next = nreq;
            sh_next = first;
          end
        end
        STAT_OFF, RLO_OFF, RHI_OFF: ;
        WLO_OFF:
        begin
          for (int b = 0; b < 4; b++)
            if (ws_reg[b])
              wb_next[8*b+:8] = wd_reg[8*b+:8];
        end
        WHI_OFF:
        begin
          for (int b = 0; b < 2; b++)
            if (ws_reg[b])
              wb_next[32+8*b+:8] = wd_reg[8*b+:8];
        end
        default: br_next = RESP_SLVERR;
      endcase
    end
    // register reads answered the cycle after the address
    if (arvalid && !rv_reg)
    begin
      rv_next = 1'b1;
      rr_next = RESP_OKAY;
      unique case (araddr)
        CTRL_OFF: rd_data_next = {27'd0, n_reg, rd_reg, 1'b0};
        STAT_OFF: rd_data_next = {30'd0, nack_reg, st_reg != H_IDLE};
        WLO_OFF: rd_data_next = wb_reg[31:0];
        WHI_OFF: rd_data_next = {16'd0, wb_reg[47:32]};
        RLO_OFF: rd_data_next = rb_reg[39:8];
        RHI_OFF: rd_data_next = {8'd0, rb_reg[7:0], rb_reg[55:40]};
        default:
        begin
          rd_data_next = 32'd0;
          rr_next = RESP_SLVERR;
        end
      endcase
    end
  end

  // host registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_reg <= H_IDLE;
      q_reg <= 16'd0;
      ph_reg <= 2'd0;
      bit_reg <= 4'd0;
      bidx_reg <= 4'd0;
      sh_reg <= 8'h00;
      rd_reg <= 1'b0;
      oe_reg <= 1'b0;
      sclh_reg <= 1'b1;
      nack_reg <= 1'b0;
      n_reg <= 3'd0;
      wb_reg <= 48'h0;
      rb_reg <= 56'h0;
      awh_reg <= 1'b0;
      wh_reg <= 1'b0;
      bv_reg <= 1'b0;
      rv_reg <= 1'b0;
      aa_reg <= 8'h00;
      wd_reg <= 32'h0;
      ws_reg <= 4'h0;
      br_reg <= RESP_OKAY;
      rr_reg <= RESP_OKAY;
      rd_data_reg <= 32'h0;
    end
    else
    begin
      st_reg <= st_next;
      q_reg <= q_next;
      ph_reg <= ph_next;
      bit_reg <= bit_next;
      bidx_reg <= bidx_next;
      sh_reg <= sh_next;
      rd_reg <= rd_next;
      oe_reg <= oe_next;
      sclh_reg <= sclh_next;
      nack_reg <= nack_next;
      n_reg <= n_next;
      wb_reg <= wb_next;
      rb_reg <= rb_next;
      awh_reg <= awh_next;
      wh_reg <= wh_next;
      bv_reg <= bv_next;
      rv_reg <= rv_next;
      aa_reg <= aa_next;
      wd_reg <= wd_next;
      ws_reg <= ws_next;
      br_reg <= br_next;
      rr_reg <= rr_next;
      rd_data_reg <= rd_data_next;
    end
  end

  assign awready = ~awh_reg;
  assign wready = ~wh_reg;
  assign bvalid = bv_reg;
  assign bresp = br_reg;
  assign arready = ~rv_reg;
  assign rvalid = rv_reg;
  assign rresp = rr_reg;
  assign rdata = rd_data_reg;
  assign bus.scl_out = sclh_reg;
  assign bus.scl_oe = 1'b1;
  assign bus.host_sda_out = 1'b0;
  assign bus.host_sda_oe = oe_reg;
endmodule // cfg_host

// ==== tb/cfg_link_checker.sv ====
// timing checks on the two-wire link between host and device
module cfg_link_checker #(
  parameter int QTR = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic host_sda_out,
  input wire logic host_sda_oe,
  input wire logic dev_sda_out,
  input wire logic dev_sda_oe,
  input wire logic scl_line,
  input wire logic sda_line
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SCL_WAIT = QTR + 2;
  logic [31:0] low_reg;
  logic [31:0] low_next;
  logic [31:0] high_reg;
  logic [31:0] high_next;

  default clocking link_cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // run lengths of the clock line levels
  always_comb
  begin
    low_next = scl_line ? 32'h0 : low_reg + 32'h1;
    high_next = scl_line ? high_reg + 32'h1 : 32'h0;
  end

  // register the run lengths
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      low_reg <= 32'h0;
      high_reg <= 32'h0;
    end
    else
    begin
      low_reg <= low_next;
      high_reg <= high_next;
    end
  end

  // clock ownership and open-drain data
  scl_driven_a: assert property (scl_oe)
    else $error("clock line not driven by host");
  dev_open_drain_a: assert property (!dev_sda_out && (high_reg <= 3 * QTR || !dev_sda_oe))
    else $error("device drives data line high or holds it on an idle bus");
  // device data changes only while clock low, after the sync lag
  dev_still_high_a: assert property (scl_line && $past(scl_line) |-> $stable(dev_sda_oe))
    else $error("device data moved while clock high");
  dev_rise_low_a: assert property ($rose(dev_sda_oe) |-> !scl_line && !$past(scl_line))
    else $error("device pulled data low near clock edge");
  dev_sync_lag_a: assert property ($fell(scl_line) |-> $stable(dev_sda_oe) [*2])
    else $error("device reacted before clock fall was synced");
  // framing: start then clock low, stop then bus free
  start_clock_low_a: assert property (scl_line && $past(scl_line) && $fell(sda_line) |-> ##[1:SCL_WAIT] !scl_line)
    else $error("clock did not follow start condition");
  stop_bus_free_a: assert property (scl_line && $past(scl_line) && $rose(sda_line) |-> scl_line [*3])
    else $error("clock moved after stop condition");
  // clock phases no shorter than the bit rate allows
  scl_low_min_a: assert property ($rose(scl_line) |-> low_reg >= QTR)
    else $error("clock low phase too short");
  scl_high_min_a: assert property ($fell(scl_line) |-> high_reg >= 2 * QTR)
    else $error("clock high phase too short");
endmodule  // cfg_link_checker

// ==== tb/test_clock_driver_i2c_config.sv ====
// bench: host joined to device, plus a bench-driven second device
module test_clock_driver_i2c_config;
  timeunit 1ns;
  timeprecision 1ns;
  import cfg_pkg::*;
  localparam int QTR = 4;
  logic aclk = 1'b0;
  logic aresetn;
  logic [7:0] awaddr;
  logic awvalid;
  logic awready;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic wvalid;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready;
  logic [7:0] araddr;
  logic arvalid;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready;
  logic [9:0] pe_a;
  logic tm_a;
  logic bm_a;
  logic [9:0] pe_b;
  logic tm_b;
  logic bm_b;
  logic [7:0] mdl [6];
  int fails = 0;
  int comparisons = 0;

  cfg_bus_if bus_link();
  cfg_bus_if bus_drv();

  // 125 MHz clock
  always #4 aclk = ~aclk;

  // designs and checker
  cfg_host #(.QTR(QTR)) u_cfg_host (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .bus(bus_link));
  cfg_device u_cfg_device (.aclk(aclk), .aresetn(aresetn), .bus(bus_link), .pair_enable(pe_a),
    .tristate_mode(tm_a), .bypass_mode(bm_a));
  cfg_device u_cfg_device2 (.aclk(aclk), .aresetn(aresetn), .bus(bus_drv), .pair_enable(pe_b),
    .tristate_mode(tm_b), .bypass_mode(bm_b));
  cfg_link_checker #(.QTR(QTR)) u_cfg_link_checker (.aclk(aclk), .aresetn(aresetn),
    .scl_out(bus_link.scl_out), .scl_oe(bus_link.scl_oe), .host_sda_out(bus_link.host_sda_out),
    .host_sda_oe(bus_link.host_sda_oe), .dev_sda_out(bus_link.dev_sda_out),
    .dev_sda_oe(bus_link.dev_sda_oe), .scl_line(bus_link.scl_line), .sda_line(bus_link.sda_line));

  // compare and count
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // counts and verdict, ends the run
  task automatic print_verdict;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // axi write, address and data offered together
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    while (!(aw_ok && w_ok))
    begin
      @(negedge aclk);
      aw_ok = aw_ok || awready;
      w_ok = w_ok || wready;
      @(posedge aclk);
      if (aw_ok)
        awvalid <= 1'b0;
      if (w_ok)
        wvalid <= 1'b0;
    end
    do
      @(negedge aclk);
    while (!bvalid);
    r = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  // axi read, answer taken at the falling edge where rvalid is first seen
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
      @(negedge aclk);
    while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    do
      @(negedge aclk);
    while (!rvalid);
    d = rdata;
    r = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  // expected device outputs from two latch values
  task automatic chk_outs(input logic [9:0] pe, input logic tm, input logic bm, input logic [7:0] l0,
    input logic [7:0] l1);
    logic [9:0] p;
    for (int i = 0; i < 8; i++)
      p[i] = l0[7-i];
    p[8] = l1[PAIR8_BIT];
    p[9] = l1[PAIR9_BIT];
    check("pair_enable", 32'(pe), 32'(p));
    check("tristate", 32'(tm), 32'(l1[TRI_BIT]));
    check("bypass", 32'(bm), 32'(l1[BYP_BIT]));
  endtask

  // start a host transfer and wait for busy to rise and fall
  task automatic host_go(input logic rd, input logic [2:0] n);
    logic [31:0] d;
    logic [1:0] r;
    axi_wr(CTRL_OFF, 32'({n, rd, 1'b1}), r);
    check("ctrl_resp", 32'(r), 32'(RESP_OKAY));
    do
      axi_rd(STAT_OFF, d, r);
    while (!d[STAT_BUSY_BIT]);
    do
      axi_rd(STAT_OFF, d, r);
    while (d[STAT_BUSY_BIT]);
    check("nack", 32'(d[STAT_NACK_BIT]), 32'h0);
    check("idle", {30'h0, bus_link.scl_line, bus_link.sda_line}, 32'h3);
  endtask

  // block read and compare with the model
  task automatic readback;
    logic [31:0] d;
    logic [1:0] r;
    host_go(1'b1, 3'd0);
    axi_rd(RLO_OFF, d, r);
    check("rlo", d, {mdl[3], mdl[2], mdl[1], mdl[0]});
    check("rlo_resp", 32'(r), 32'(RESP_OKAY));
    axi_rd(RHI_OFF, d, r);
    check("rhi", {8'h0, d[23:0]}, {8'h0, 8'(NUM_LATCH), mdl[5], mdl[4]});
    chk_outs(pe_a, tm_a, bm_a, mdl[0], mdl[1]);
  endtask

  // bench-driven link: quarter wait, bit, byte with ack, start, stop
  task automatic qwait;
    repeat (QTR) @(posedge aclk);
  endtask
  task automatic bb_bit(input logic b, output logic s);
    bus_drv.host_sda_oe <= ~b;
    qwait;
    bus_drv.scl_out <= 1'b1;
    qwait;
    s = bus_drv.sda_line;
    qwait;
    bus_drv.scl_out <= 1'b0;
    qwait;
  endtask
  task automatic bb_byte(input logic [7:0] v, input logic ea);
    logic s;
    for (int i = 7; i >= 0; i--)
      bb_bit(v[i], s);
    bb_bit(1'b1, s);
    check("ack", {31'h0, s}, {31'h0, ~ea});
  endtask
  task automatic bb_start;
    bus_drv.host_sda_oe <= 1'b1;
    qwait;
    bus_drv.scl_out <= 1'b0;
    qwait;
  endtask
  task automatic bb_stop;
    bus_drv.host_sda_oe <= 1'b1;
    qwait;
    bus_drv.scl_out <= 1'b1;
    qwait;
    bus_drv.host_sda_oe <= 1'b0;
    qwait;
  endtask

  // main sequence
  initial
  begin
    logic [31:0] wlo;
    logic [31:0] whi;
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] b0;
    logic [7:0] b1;
    logic s;
    aresetn <= 1'b0;
    awaddr <= 8'h00;
    awvalid <= 1'b0;
    wdata <= 32'h0;
    wstrb <= 4'hf;
    wvalid <= 1'b0;
    bready <= 1'b0;
    araddr <= 8'h00;
    arvalid <= 1'b0;
    rready <= 1'b0;
    bus_drv.scl_out <= 1'b1;
    bus_drv.scl_oe <= 1'b1;
    bus_drv.host_sda_out <= 1'b0;
    bus_drv.host_sda_oe <= 1'b0;
    mdl = '{LATCH0_DEF, LATCH1_DEF, LATCH2_DEF, LATCH3_DEF, LATCH4_DEF, LATCH5_DEF};
    void'($urandom(22280));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    chk_outs(pe_a, tm_a, bm_a, LATCH0_DEF, LATCH1_DEF);
    readback;
    // every byte count, including clamped ones past latch 4
    for (int n = 0; n < 8; n++)
    begin
      wlo = $urandom();
      whi = $urandom();
      axi_wr(WLO_OFF, wlo, r);
      axi_wr(WHI_OFF, whi, r);
      check("whi_resp", 32'(r), 32'(RESP_OKAY));
      axi_rd(WLO_OFF, d, r);
      check("wlo", d, wlo);
      host_go(1'b0, 3'(n));
      for (int k = 0; k < 5 && k < n; k++)
        mdl[k] = (k < 4) ? wlo[8*k +: 8] : whi[7:0];
      readback;
    end
    axi_wr(8'h18, $urandom(), r);
    check("unmapped_wr", 32'(r), 32'(RESP_SLVERR));
    axi_rd(8'h1c, d, r);
    check("unmapped_rd", {d[29:0], r}, {30'h0, RESP_SLVERR});
    // foreign address on the driven link
    bb_start;
    bb_byte(8'ha4, 1'b0);
    bb_byte(8'h00, 1'b0);
    bb_stop;
    chk_outs(pe_b, tm_b, bm_b, LATCH0_DEF, LATCH1_DEF);
    // full write, then a rewrite aborted inside its second data byte
    b0 = 8'($urandom());
    b1 = 8'($urandom());
    for (int t = 0; t < 2; t++)
    begin
      bb_start;
      bb_byte(WR_ADDR, 1'b1);
      bb_byte(8'($urandom()), 1'b1);
      bb_byte(8'($urandom()), 1'b1);
      if (t == 1)
        b0 = ~b0;
      bb_byte(b0, 1'b1);
      if (t == 0)
        bb_byte(b1, 1'b1);
      else
        repeat (4) bb_bit(~b1[7], s);
      bb_stop;
      chk_outs(pe_b, tm_b, bm_b, b0, b1);
    end
    print_verdict;
  end

  // hang guard, well beyond the expected run
  initial
  begin
    repeat (80000) @(posedge aclk);
    fails++;
    print_verdict;
  end
endmodule  // test_clock_driver_i2c_config
